/* logic/osc_top.sv */
// Purpose: ORing switch control with AHB-Lite config and status
// Assumes: Sense words are synchronous samples; fast comparator is a pin
// Notes: Zero wait states while ce is high; ce low stalls the bus
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.

`timescale 1ns/10ps
`default_nettype none

module osc_top #(
  parameter int ADC_W = 12,
  parameter int CS_W = 12,
  parameter int CS_UV_PER_LSB = 250,
  parameter int DEB_CNT_W = 4
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Voltage sense samples
  input wire logic [ADC_W-1:0] local_voltage_sense,
  input wire logic [ADC_W-1:0] remote_side_voltage_sense,
  // Current sense samples
  input wire logic [CS_W-1:0] secondary_current_sense_pos,
  input wire logic [CS_W-1:0] secondary_current_sense_neg,
  // Fast comparator
  input wire logic fast_cmp_trip,
  output logic [1:0] fast_disable_threshold,
  // Switch drive and flags
  output logic oring_switch,
  output logic accurate_flag
);

  localparam int FULL_RANGE = 1 << ADC_W;
  localparam int ACC_THR_CNT =
    (osc_pkg::ACC_THR_MV_CODE0 * 1000) / CS_UV_PER_LSB;

  // Bus address phase capture
  logic [7:0] cfg_ff;
  logic wr_pend_ff;
  logic [31:0] waddr_ff;
  logic [31:0] hrdata_ff;

  wire addr_ok = hsel && htrans[1] && hready && ce;
  wire wr_req = addr_ok && hwrite;
  wire rd_req = addr_ok && !hwrite;
  wire rd_cfg = (haddr == osc_pkg::CFG_OFFSET);
  wire rd_stat = (haddr == osc_pkg::STAT_OFFSET);
  wire wr_cfg = wr_pend_ff && ce &&
    (waddr_ff == osc_pkg::CFG_OFFSET);
  // Read addressed in a write's data phase
  // returns the config from before that write

  // Config fields
  wire [1:0] acc_code = cfg_ff[osc_pkg::ACC_THR_LSB +: 2];
  wire [1:0] en_code = cfg_ff[osc_pkg::EN_THR_LSB +: 2];
  wire [1:0] fast_code = cfg_ff[osc_pkg::FAST_THR_LSB +: 2];
  wire fast_disable_debounce_sel = cfg_ff[osc_pkg::DEB_SEL_BIT];
  wire fast_disable_bypass = cfg_ff[osc_pkg::BYPASS_BIT];

  // Core state
  logic en_cond_ff;
  logic acc_flag_ff;
  osc_pkg::osc_sw_e sw_ff;
  osc_pkg::osc_sw_e nxt_sw;
  logic fast_sync;
  logic fast_trip;

  wire [7:0] status_word = {4'h0, en_cond_ff, fast_trip,
    acc_flag_ff, sw_ff == osc_pkg::SW_ON};
  wire [31:0] rd_mux = rd_cfg ? {24'h00_0000, cfg_ff} :
    (rd_stat ? {24'h00_0000, status_word} : 32'h0000_0000);

  // Stall only while the block is frozen
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= 32'h0000_0000;
      hrdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_ff <= wr_req;
      if (wr_req) begin
        waddr_ff <= haddr;
      end
      if (rd_req) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // Only the low byte lane carries config bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= osc_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= hwdata[7:0];
    end
  end

  assign fast_disable_threshold = fast_code;

  // Signed differences, one bit wider than the samples
  wire signed [ADC_W:0] vdiff =
    $signed({1'b0, local_voltage_sense}) -
    $signed({1'b0, remote_side_voltage_sense});
  wire signed [CS_W:0] csdiff =
    $signed({1'b0, secondary_current_sense_pos}) -
    $signed({1'b0, secondary_current_sense_neg});
  wire signed [ADC_W:0] en_thr =
    (ADC_W+1)'(osc_pkg::en_thr_counts(en_code, FULL_RANGE));
  // All four accurate codes use the code 00 threshold of 0 mV
  wire signed [CS_W:0] acc_thr = (CS_W+1)'(ACC_THR_CNT);
  wire en_hit = (vdiff >= en_thr);
  wire acc_hit = (csdiff <= acc_thr) && (acc_code inside {2'b00,
    2'b01, 2'b10, 2'b11});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_cond_ff <= 1'b0;
      acc_flag_ff <= 1'b0;
    end else if (ce) begin
      en_cond_ff <= en_hit;
      acc_flag_ff <= acc_hit;
    end
  end

  // Pin pulses shorter than two clocks may be lost;
  // fast path latency is bought for metastability safety
  osc_sync3 u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in(fast_cmp_trip),
    .sync_out(fast_sync)
  );

  osc_debounce #(
    .CNT_W(DEB_CNT_W)
  ) u_deb (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .cond(fast_sync),
    .sel_long(fast_disable_debounce_sel),
    .trip(fast_trip)
  );

  wire fast_off = fast_trip && !fast_disable_bypass;
  wire any_off = fast_off || acc_flag_ff;

  always_comb begin
    nxt_sw = sw_ff;
    unique case (sw_ff)
      osc_pkg::SW_OFF: begin
        if (en_cond_ff && !any_off) begin
          nxt_sw = osc_pkg::SW_ON;
        end
      end
      osc_pkg::SW_ON: begin
        if (any_off) begin
          nxt_sw = osc_pkg::SW_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_ff <= osc_pkg::SW_OFF;
    end else if (ce) begin
      sw_ff <= nxt_sw;
    end
  end

  assign oring_switch = (sw_ff == osc_pkg::SW_ON);
  assign accurate_flag = acc_flag_ff;

  // Checking helpers: run length of the synchronised condition
  localparam int SHORT_CYC = osc_pkg::DEB_SHORT_CYC;
  localparam int LONG_CYC = osc_pkg::DEB_LONG_CYC;
  logic [7:0] run_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= 8'h00;
    end else if (ce) begin
      if (!fast_sync) begin
        run_ff <= 8'h00;
      end else if (run_ff != 8'hff) begin
        run_ff <= run_ff + 8'h01;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  en_thr_a: assert property (
    $past(ce) && $past(hresetn) |-> en_cond_ff == $past(en_hit))
    else $error("enable condition does not follow threshold");

  sw_on_a: assert property (
    $rose(oring_switch) |-> $past(en_cond_ff) && !$past(any_off))
    else $error("switch turned on without enable condition");

  fast_off_a: assert property (
    ce && oring_switch && fast_trip && !fast_disable_bypass
    |=> !oring_switch)
    else $error("fast trip did not turn switch off");

  fast_code_a: assert property (
    wr_cfg ##1 ce |-> fast_disable_threshold ==
      $past(hwdata[osc_pkg::FAST_THR_LSB +: 2], 1))
    else $error("fast threshold code not driven from config");

  deb_short_a: assert property (
    $rose(fast_trip) |-> run_ff >= 8'(SHORT_CYC))
    else $error("fast trip before short debounce elapsed");

  deb_long_a: assert property (
    $rose(fast_trip) && $past(fast_disable_debounce_sel)
    |-> run_ff >= 8'(LONG_CYC))
    else $error("fast trip before long debounce elapsed");

  deb_restart_a: assert property (
    ce && !fast_sync |=> !fast_trip)
    else $error("fast trip held after condition cleared");

  deb_full_a: assert property (
    ce && fast_sync && !fast_disable_debounce_sel
    && run_ff == 8'(SHORT_CYC - 1) |=> fast_trip)
    else $error("fast trip late after short interval");

  bypass_a: assert property (
    $fell(oring_switch) |-> $past(acc_flag_ff) ||
      ($past(fast_trip) && !$past(fast_disable_bypass)))
    else $error("switch off without an enabled disable cause");

  acc_flag_a: assert property (
    $past(ce) && $past(hresetn) |-> accurate_flag == $past(acc_hit))
    else $error("accurate flag does not follow threshold");

  acc_off_a: assert property (
    ce && oring_switch && accurate_flag |=> !oring_switch)
    else $error("accurate flag did not turn switch off");

  sw_on_late_a: assert property (
    ce && !oring_switch && en_cond_ff && !any_off |=> oring_switch)
    else $error("switch stayed off with enable condition met");

  off_hold_a: assert property (
    ce && !oring_switch && any_off |=> !oring_switch)
    else $error("switch turned on while a disable cause stood");

  deb_long_full_a: assert property (
    ce && fast_sync && fast_disable_debounce_sel
    && run_ff == 8'(LONG_CYC - 1) |=> fast_trip)
    else $error("fast trip late after long interval");

  bypass_keep_a: assert property (
    ce && fast_disable_bypass && !acc_flag_ff && oring_switch
    |=> oring_switch)
    else $error("switch dropped while fast path bypassed");

  sw_on_c: cover property ($rose(oring_switch));
  fast_dis_c: cover property (
    $fell(oring_switch) && $past(fast_trip));
  long_deb_c: cover property (
    $rose(fast_trip) && fast_disable_debounce_sel);
  bypass_c: cover property (
    fast_disable_bypass && $fell(oring_switch) && $past(acc_flag_ff));
  restart_c: cover property (
    fast_sync ##1 !fast_sync ##1 fast_sync);

endmodule

`default_nettype wire

/* shared/osc_pkg.sv */
// Purpose: Shared constants for the ORing switch control block
// Assumes: 40 MHz bus clock, 32-bit AHB-Lite register access
// Notes: Config register fields follow the documented bit layout

package osc_pkg;

  // Register byte offsets
  localparam logic [31:0] CFG_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STAT_OFFSET = 32'h0000_0004;

  // Config register reset value
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Config field positions
  localparam int ACC_THR_LSB = 6;
  localparam int EN_THR_LSB = 4;
  localparam int FAST_THR_LSB = 2;
  localparam int DEB_SEL_BIT = 1;
  localparam int BYPASS_BIT = 0;

  // Status field positions
  localparam int ST_SWITCH_BIT = 0;
  localparam int ST_ACC_BIT = 1;
  localparam int ST_FAST_BIT = 2;
  localparam int ST_EN_BIT = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB_SHORT_NS = 40;
  localparam int DEB_LONG_NS = 200;
  localparam int DEB_SHORT_CYC =
    (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_LONG_CYC =
    (DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Enable threshold in tenths of a percent of full range
  localparam int EN_PM_CODE0 = -5;
  localparam int EN_PM_CODE1 = 0;
  localparam int EN_PM_CODE2 = 10;
  localparam int EN_PM_CODE3 = 20;

  // Accurate flag threshold, code 00
  localparam int ACC_THR_MV_CODE0 = 0;

  typedef enum logic {SW_OFF, SW_ON} osc_sw_e;

  // Enable threshold in sense converter counts
  function automatic int en_thr_counts(input logic [1:0] code,
                                       input int full_range);
    int pm;
    pm = EN_PM_CODE0;
    unique case (code)
      2'b00: pm = EN_PM_CODE0;
      2'b01: pm = EN_PM_CODE1;
      2'b10: pm = EN_PM_CODE2;
      2'b11: pm = EN_PM_CODE3;
    endcase
    return (pm * full_range) / 1000;
  endfunction

endpackage

/* logic/osc_sync3.sv */
// Purpose: Three-stage synchroniser for the fast comparator pin
// Assumes: Input is asynchronous to hclk
// Notes: Output moves only when the second and third stages agree

`timescale 1ns/10ps
`default_nettype none

module osc_sync3 (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Data
  input wire logic async_in,
  output logic sync_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  wire agree = (s2_ff == s3_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      out_ff <= 1'b0;
    end else if (ce) begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        out_ff <= s3_ff;
      end
    end
  end

  assign sync_out = out_ff;

endmodule

`default_nettype wire

/* logic/osc_debounce.sv */
// Purpose: Debounce counter for the fast disable comparator
// Assumes: cond is already synchronous to hclk
// Notes: trip rises after cond held for the selected cycle count

`timescale 1ns/10ps
`default_nettype none

module osc_debounce #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control
  input wire logic cond,
  input wire logic sel_long,
  // Result
  output logic trip
);

  localparam logic [CNT_W-1:0] SHORT_LIM =
    CNT_W'(osc_pkg::DEB_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] LONG_LIM =
    CNT_W'(osc_pkg::DEB_LONG_CYC - 1);

  logic [CNT_W-1:0] cnt_ff;
  logic trip_ff;
  wire [CNT_W-1:0] limit = sel_long ? LONG_LIM : SHORT_LIM;
  wire reached = cond && (cnt_ff >= limit);
  wire [CNT_W-1:0] nxt_cnt = !cond ? '0 :
    (reached ? cnt_ff : cnt_ff + CNT_W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      trip_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      trip_ff <= reached;
    end
  end

  assign trip = trip_ff;

endmodule

`default_nettype wire

/* sim/osc_sense_model.sv */
// Purpose: Far side model: sense resistor and fast comparator
// Assumes: 250 uV per current-sense LSB, mid-scale offset on both inputs
// Notes: Averaged drop feeds the samples; instant drop feeds the comparator

`timescale 1ns/10ps
`default_nettype none

module osc_sense_model #(
  parameter int CS_W = 12
) (
  // Comparator setting
  input wire logic [1:0] fast_disable_threshold,
  // Drop across sense resistor in mV
  input wire logic signed [15:0] fast_mv,
  input wire logic signed [15:0] avg_mv,
  // Sense outputs
  output logic [CS_W-1:0] secondary_current_sense_pos,
  output logic [CS_W-1:0] secondary_current_sense_neg,
  output logic fast_cmp_trip
);
  logic signed [15:0] thr_mv;

  assign thr_mv = 16'(-100 + 25 * int'(fast_disable_threshold));
  assign fast_cmp_trip = (fast_mv <= thr_mv);
  // Sample filter hides short spikes from the accurate path
  assign secondary_current_sense_pos = CS_W'(2048 + 4 * int'(avg_mv));
  assign secondary_current_sense_neg = CS_W'(2048);
endmodule
`default_nettype wire

/* sim/tb_oring_switch_control.sv */
// Purpose: Self-checking bench for the ORing switch control block
// Assumes: ce held high, so the slave answers with no wait states
// Notes: Sticky drop monitor catches short switch-off glitches

`timescale 1ns/10ps
`default_nettype none

module tb_oring_switch_control;
  logic hclk, hresetn, ce, hwrite, hreadyout, hresp, sw, acc, trip, dropped;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, fthr;
  logic [11:0] vloc, vrem, cpos, cneg;
  logic signed [15:0] fast_mv, avg_mv;
  int n_fail, compares, cyc, thr;
  int pm [4] = '{-5, 0, 10, 20};

  osc_top u_osc_top (.hclk, .hresetn, .ce, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .local_voltage_sense(vloc),
    .remote_side_voltage_sense(vrem), .secondary_current_sense_pos(cpos),
    .secondary_current_sense_neg(cneg), .fast_cmp_trip(trip),
    .fast_disable_threshold(fthr), .oring_switch(sw), .accurate_flag(acc));

  osc_sense_model u_osc_sense_model (.fast_disable_threshold(fthr),
    .fast_mv, .avg_mv, .secondary_current_sense_pos(cpos),
    .secondary_current_sense_neg(cneg), .fast_cmp_trip(trip));

  initial begin
    hclk = 0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic final_report;
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (sw === 1'b0)
      dropped = 1'b1;
    if (cyc == 4000) begin
      n_fail++;
      final_report;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
    @(posedge hclk);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_sw(input logic v, input int lim);
    int i;
    i = 0;
    while (sw !== v && i < lim) begin
      @(posedge hclk);
      i++;
    end
    chk("oring_switch", {31'h0, sw}, {31'h0, v});
  endtask

  // Holds the fast drop for n cycles, then recovers
  task automatic pulse(input int n);
    @(posedge hclk);
    fast_mv <= -16'sd100;
    repeat (n) @(posedge hclk);
    fast_mv <= 16'sd0;
    repeat (4) @(posedge hclk);
  endtask

  initial begin
    hresetn = 0;
    ce = 1;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hwdata = 0;
    vloc = 12'd2000;
    vrem = 12'd2000;
    fast_mv = 0;
    avg_mv = 16'sd10;
    dropped = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    xfer(0, 32'h0, 32'h0, rd);
    chk("cfg_reset", rd, 32'h0000_0000);
    xfer(1, 32'h0, 32'hABCD_12F5, rd);
    xfer(0, 32'h0, 32'h0, rd);
    chk("cfg_rw", rd, 32'h0000_00F5);
    xfer(1, 32'h8, 32'hFFFF_FFFF, rd);
    xfer(0, 32'h8, 32'h0, rd);
    chk("unmapped", rd, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      thr = (pm[c] * 4096) / 1000;
      xfer(1, 32'h0, 32'(c) << 4, rd);
      for (int k = 0; k < 2; k++) begin
        @(posedge hclk);
        vloc <= 12'(2000 + thr - k);
        repeat (3) @(posedge hclk);
        xfer(0, 32'h4, 32'h0, rd);
        chk("enable_cond", {31'h0, rd[3]}, 32'(1 - k));
      end
    end
    vloc <= 12'd2000;
    for (int c = 0; c < 4; c++) begin
      xfer(1, 32'h0, 32'(c) << 2, rd);
      @(posedge hclk);
      chk("fast_thr", {30'h0, fthr}, 32'(c));
      fast_mv <= 16'(-100 + 25 * c);
      wait_sw(1'b0, 10);
      fast_mv <= 16'sd0;
      wait_sw(1'b1, 10);
    end
    dropped = 0;
    pulse(6);
    chk("short_deb", {31'h0, dropped}, 32'h1);
    xfer(1, 32'h0, 32'h2, rd);
    dropped = 0;
    pulse(6);
    pulse(6);
    chk("long_restart", {31'h0, dropped}, 32'h0);
    @(posedge hclk);
    fast_mv <= -16'sd100;
    wait_sw(1'b0, 16);
    fast_mv <= 16'sd0;
    xfer(0, 32'h4, 32'h0, rd);
    chk("fast_status", {29'h0, rd[2:0]}, 32'h4);
    wait_sw(1'b1, 10);
    xfer(1, 32'h0, 32'h1, rd);
    dropped = 0;
    pulse(20);
    chk("bypass", {31'h0, dropped}, 32'h0);
    avg_mv <= 16'sd0;
    wait_sw(1'b0, 10);
    chk("acc_flag", {31'h0, acc}, 32'h1);
    xfer(0, 32'h4, 32'h0, rd);
    chk("acc_status", {30'h0, rd[1:0]}, 32'h2);
    avg_mv <= 16'sd10;
    wait_sw(1'b1, 10);
    chk("acc_clear", {31'h0, acc}, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
